// file: hdl/meter_pulse_and_serial_timing.v
// pulse width, strobe and serial-mode pin sharing logic of a meter front end
// ****************************************************************
// Overview of operation
// R1: ready strobe lasts exactly four clock periods
// R2: host finishes entry code within 32 periods
// R3: host starts entry code after one period
// R4: counter-drive low width halves on short periods
// R5: calibration width halves on short periods
// R6: select code 0,1,1 fixes width at 64
// R7: serial pins double as frequency selects
// R8: data output carries read data or negative flag
// R9: counter-drive low width is 984376 periods
// R10: calibration pulse width is 322160 periods
// R11: high-pass input enables both offset filters
// R12: negative flag updates on calibration rising edge
// R13: entry window from master clear, sampled rising clock
// ****************************************************************
`timescale 1ns/1ps
`include "meter_pulse_consts.vh"
module meter_pulse_and_serial_timing #(
  parameter CW = 21,
  parameter COUNTER_LOW_WIDTH = `COUNTER_LOW_WIDTH,
  parameter CALIB_WIDTH = `CALIB_WIDTH
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_master_clear_n,
  input wire i_offset_filter_enable,
  input wire i_sck_freq_sel_hi,
  input wire i_sdi_freq_sel_mid,
  input wire i_cs_n_freq_sel_lo,
  input wire i_counter_event,
  input wire i_calib_event,
  input wire i_power_negative,
  input wire i_sample_ready,
  input wire i_read_data,
  output reg o_calib_pulse_out,
  output reg o_counter_drive_a,
  output reg o_counter_drive_b,
  output reg o_sdo_negative,
  output reg o_ready_strobe,
  output reg o_serial_mode,
  output reg o_filter_ch0_enable,
  output reg o_filter_ch1_enable,
  output reg [2:0] o_freq_sel
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {i_master_clear_n, i_offset_filter_enable,
                    i_sck_freq_sel_hi, i_sdi_freq_sel_mid,
                    i_cs_n_freq_sel_lo};
      sync2_reg <= sync1_reg;
    end
  end
  wire clear_n_s = sync2_reg[4];
  wire filt_s = sync2_reg[3];
  wire sck = sync2_reg[2];
  wire sdi = sync2_reg[1];
  wire cs_n = sync2_reg[0];
  wire clr = i_reset | ~clear_n_s;

  // ****************************************************************
  // serial-mode entry
  // ****************************************************************
  reg [5:0] win_reg;
  reg sck_d_reg;
  reg [`ENTRY_CODE_BITS-1:0] code_reg;
  reg [3:0] nbits_reg;
  reg entry_done_reg;
  wire sck_rise = sck & ~sck_d_reg;
  wire [`ENTRY_CODE_BITS-1:0] code_next = {code_reg[`ENTRY_CODE_BITS-2:0],
                                           sdi};
  // window counter runs from release of master clear
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      win_reg <= 6'h00;
      sck_d_reg <= 1'b0;
      code_reg <= {`ENTRY_CODE_BITS{1'b0}};
      nbits_reg <= 4'h0;
      entry_done_reg <= 1'b0;
      o_serial_mode <= 1'b0;
    end else if (!clear_n_s) begin
      win_reg <= 6'h00; // R13
      sck_d_reg <= sck;
      code_reg <= {`ENTRY_CODE_BITS{1'b0}};
      nbits_reg <= 4'h0;
      entry_done_reg <= 1'b0;
      o_serial_mode <= 1'b0;
    end else begin
      sck_d_reg <= sck;
      if (win_reg != 6'h3F)
        win_reg <= win_reg + 6'h01;
      // bits before the earliest time or after the deadline are ignored
      if (!entry_done_reg && sck_rise && !cs_n &&
          win_reg >= `ENTRY_CODE_EARLIEST &&
          win_reg < `ENTRY_CODE_DEADLINE) begin // R2 R3 R13
        code_reg <= code_next;
        nbits_reg <= nbits_reg + 4'h1;
        if (nbits_reg == `ENTRY_CODE_BITS - 1) begin
          entry_done_reg <= 1'b1;
          o_serial_mode <= (code_next == `ENTRY_CODE_VALUE);
        end
      end
      if (win_reg >= `ENTRY_CODE_DEADLINE)
        entry_done_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // pin sharing, filters and negative flag
  // ****************************************************************
  reg calib_d_reg;
  reg minus_reg;
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_freq_sel <= 3'h0;
      o_filter_ch0_enable <= 1'b0;
      o_filter_ch1_enable <= 1'b0;
      o_sdo_negative <= 1'b0;
      calib_d_reg <= 1'b0;
      minus_reg <= 1'b0;
    end else begin
      if (!o_serial_mode)
        o_freq_sel <= {sck, sdi, cs_n}; // R7
      o_filter_ch0_enable <= filt_s; // R11
      o_filter_ch1_enable <= filt_s; // R11
      calib_d_reg <= o_calib_pulse_out;
      if (clr)
        minus_reg <= 1'b0;
      else if (o_calib_pulse_out && !calib_d_reg)
        minus_reg <= i_power_negative; // R12
      o_sdo_negative <= o_serial_mode ? i_read_data : minus_reg; // R8
    end
  end

  // ****************************************************************
  // data-ready strobe
  // ****************************************************************
  reg [2:0] dr_cnt_reg;
  localparam [31:0] DR_LOAD = `READY_STROBE_WIDTH - 1;
  // strobe stands four cycles, requests while it stands are ignored
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      dr_cnt_reg <= 3'h0;
      o_ready_strobe <= 1'b0;
    end else if (!clear_n_s) begin
      dr_cnt_reg <= 3'h0;
      o_ready_strobe <= 1'b0;
    end else if (dr_cnt_reg != 3'h0) begin
      dr_cnt_reg <= dr_cnt_reg - 3'h1;
      o_ready_strobe <= 1'b1; // R1
    end else if (i_sample_ready && !o_ready_strobe) begin
      dr_cnt_reg <= DR_LOAD[2:0];
      o_ready_strobe <= 1'b1; // R1
    end else begin
      o_ready_strobe <= 1'b0;
    end
  end

  // ****************************************************************
  // pulse outputs
  // ****************************************************************
  localparam [31:0] FIX_LOAD = `CALIB_FIXED_WIDTH - 1;
  wire cal_fixed = (o_freq_sel == `CALIB_FIXED_CODE); // R6
  wire [CW-1:0] cal_width = CALIB_WIDTH[CW-1:0]; // R10
  wire cal_active;
  wire cnt_active;
  reg side_reg;
  reg [CW-1:0] fix_cnt_reg;
  reg fix_active_reg;
  // fixed-width calibration pulse, never halved by a short period
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      fix_cnt_reg <= {CW{1'b0}};
      fix_active_reg <= 1'b0;
    end else if (!clear_n_s) begin
      fix_cnt_reg <= {CW{1'b0}};
      fix_active_reg <= 1'b0;
    end else if (i_calib_event) begin
      fix_cnt_reg <= FIX_LOAD[CW-1:0];
      fix_active_reg <= 1'b1; // R6
    end else if (fix_cnt_reg != {CW{1'b0}}) begin
      fix_cnt_reg <= fix_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      fix_active_reg <= 1'b0;
    end
  end
  // calibration pulse, halved on short periods
  pulse_shaper #(.CW(CW)) u_calib (
    .i_core_clk(i_core_clk),
    .i_reset(clr),
    .i_trigger(i_calib_event),
    .i_width(cal_width), // R5
    .o_active(cal_active)
  );
  // counter-drive low phase, halved on short periods
  pulse_shaper #(.CW(CW)) u_count (
    .i_core_clk(i_core_clk),
    .i_reset(clr),
    .i_trigger(i_counter_event),
    .i_width(COUNTER_LOW_WIDTH[CW-1:0]), // R9 R4
    .o_active(cnt_active)
  );
  // the two counter outputs alternate pulses, idle high
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      side_reg <= 1'b0;
      o_counter_drive_a <= 1'b1;
      o_counter_drive_b <= 1'b1;
      o_calib_pulse_out <= 1'b0;
    end else begin
      if (i_counter_event)
        side_reg <= ~side_reg;
      o_counter_drive_a <= ~(cnt_active & ~side_reg); // R9
      o_counter_drive_b <= ~(cnt_active & side_reg); // R9
      o_calib_pulse_out <= cal_fixed ? fix_active_reg : cal_active; // R5 R6
    end
  end
endmodule

// file: hdl/meter_pulse_consts.vh
// timing counts and codes for the metering pulse and serial timing block
`ifndef METER_PULSE_CONSTS_VH
`define METER_PULSE_CONSTS_VH
// counter-drive low width, master-clock periods
`define COUNTER_LOW_WIDTH 984376
// calibration pulse width, master-clock periods
`define CALIB_WIDTH 322160
// fixed calibration width for select code 0,1,1
`define CALIB_FIXED_WIDTH 64
`define CALIB_FIXED_CODE 3'h3
// data-ready strobe width, master-clock periods
`define READY_STROBE_WIDTH 4
// serial-mode entry window, master-clock periods
`define ENTRY_CODE_DEADLINE 32
`define ENTRY_CODE_EARLIEST 1
// serial-mode entry code and its length
`define ENTRY_CODE_BITS 8
`define ENTRY_CODE_VALUE 8'hA4
`endif

// file: hdl/pulse_shaper.v
// one pulse output stretched to a fixed or half-period width
`timescale 1ns/1ps
module pulse_shaper #(
  parameter CW = 21
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_trigger,
  input wire [CW-1:0] i_width,
  output reg o_active
);
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] period_reg;
  reg [CW-1:0] width_now;

  // width is the nominal one, or half the last period if that is shorter
  always @* begin
    width_now = i_width;
    if ({1'b0, period_reg[CW-1:1]} < i_width &&
        period_reg != {CW{1'b1}})
      width_now = {1'b0, period_reg[CW-1:1]};
    if (width_now == {CW{1'b0}})
      width_now = {{(CW-1){1'b0}}, 1'b1};
  end

  // measure the period between triggers and time the active phase
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= {CW{1'b1}}; // saturated: no period measured yet
      period_reg <= {CW{1'b1}};
      o_active <= 1'b0;
    end else begin
      if (i_trigger) begin
        // count holds cycles since last trigger minus one
        if (cnt_reg == {CW{1'b1}})
          period_reg <= cnt_reg;
        else
          period_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        cnt_reg <= {CW{1'b0}};
        o_active <= 1'b1;
      end else begin
        if (cnt_reg != {CW{1'b1}})
          cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        if (o_active && cnt_reg >= width_now - {{(CW-1){1'b0}}, 1'b1})
          o_active <= 1'b0;
      end
    end
  end
endmodule

// file: tb/meter_pulse_chk.sv
// assertion checker for the meter pulse and serial timing block
`timescale 1ns/1ps
`include "meter_pulse_consts.vh"
module meter_pulse_chk #(parameter CNT = 40, parameter CAL = 20) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_master_clear_n,
  input wire i_offset_filter_enable,
  input wire i_sck_freq_sel_hi,
  input wire i_sdi_freq_sel_mid,
  input wire i_cs_n_freq_sel_lo,
  input wire i_sample_ready,
  input wire o_calib_pulse_out,
  input wire o_counter_drive_a,
  input wire o_ready_strobe,
  input wire o_serial_mode,
  input wire o_filter_ch0_enable,
  input wire o_filter_ch1_enable,
  input wire [2:0] o_freq_sel
);
  reg [20:0] hi_reg;
  reg [20:0] lo_reg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // run lengths of the calibration pulse and the low drive pulse
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_reg <= 21'h0;
      lo_reg <= 21'h0;
    end else begin
      hi_reg <= o_calib_pulse_out ? hi_reg + 21'h1 : 21'h0;
      lo_reg <= o_counter_drive_a ? 21'h0 : lo_reg + 21'h1;
    end
  end
  property p_len; $rose(o_ready_strobe) |-> o_ready_strobe[*4] ##1
    !o_ready_strobe; endproperty
  a_len: assert property (p_len) else $error("strobe width");
  property p_go; i_sample_ready && !o_ready_strobe |=> o_ready_strobe;
    endproperty
  a_go: assert property (p_go) else $error("strobe start");
  property p_fix; $fell(o_calib_pulse_out) && o_freq_sel == 3'h3 |->
    hi_reg == 21'h40; endproperty
  a_fix: assert property (p_fix) else $error("fixed width");
  property p_cal; $fell(o_calib_pulse_out) && o_freq_sel != 3'h3 |->
    hi_reg <= CAL && hi_reg != 21'h0; endproperty
  a_cal: assert property (p_cal) else $error("calib width");
  property p_cnt; $rose(o_counter_drive_a) |-> lo_reg <= CNT; endproperty
  a_cnt: assert property (p_cnt) else $error("drive width");
  property p_flt; i_offset_filter_enable[*5] |-> o_filter_ch0_enable &&
    o_filter_ch1_enable; endproperty
  a_flt: assert property (p_flt) else $error("filter enable");
  property p_sel; (!o_serial_mode && $stable({i_sck_freq_sel_hi,
    i_sdi_freq_sel_mid, i_cs_n_freq_sel_lo}))[*5] |-> o_freq_sel ==
    {i_sck_freq_sel_hi, i_sdi_freq_sel_mid, i_cs_n_freq_sel_lo};
    endproperty
  a_sel: assert property (p_sel) else $error("select pins");
  property p_hold; o_serial_mode && i_master_clear_n |=> o_serial_mode;
    endproperty
  a_hold: assert property (p_hold) else $error("serial mode");
endmodule
bind meter_pulse_and_serial_timing meter_pulse_chk #(
  .CNT(COUNTER_LOW_WIDTH), .CAL(CALIB_WIDTH)) chk_u (.i_core_clk,
  .i_reset, .i_master_clear_n, .i_offset_filter_enable, .i_sck_freq_sel_hi,
  .i_sdi_freq_sel_mid, .i_cs_n_freq_sel_lo, .i_sample_ready,
  .o_calib_pulse_out, .o_counter_drive_a, .o_ready_strobe, .o_serial_mode,
  .o_filter_ch0_enable, .o_filter_ch1_enable, .o_freq_sel);

// file: tb/serial_host_model.sv
// serial host: select code on the shared pins, entry code in frames
`timescale 1ns/1ps
`include "meter_pulse_consts.vh"
module serial_host_model (
  input wire i_core_clk,
  input wire i_go,
  input wire [3:0] i_half,
  input wire [2:0] i_sel,
  output wire o_sck,
  output wire o_sdi,
  output wire o_cs_n
);
  localparam [7:0] CODE = `ENTRY_CODE_VALUE;
  reg busy = 1'b0;
  reg sck = 1'b0;
  reg sdi = 1'b0;
  integer i;
  // select code outside frames, chip select low within
  assign o_sck = busy ? sck : i_sel[2];
  assign o_sdi = busy ? sdi : i_sel[1];
  assign o_cs_n = busy ? 1'b0 : i_sel[0];
  // msb first, data set while the clock is low
  always @(posedge i_go) begin
    @(negedge i_core_clk);
    busy = 1'b1;
    for (i = 7; i >= 0; i = i - 1) begin
      sdi = CODE[i];
      repeat (i_half) @(negedge i_core_clk);
      sck = 1'b1;
      repeat (i_half) @(negedge i_core_clk);
      sck = 1'b0;
    end
    busy = 1'b0;
  end
endmodule

// file: tb/tb_meter_pulse_and_serial_timing.sv
// self-checking bench for the meter pulse and serial timing block
`timescale 1ns/1ps
`include "meter_pulse_consts.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_meter_pulse_and_serial_timing;
  reg clk = 0, rst = 1, clr_n = 1, filt = 0, cev = 0, hev = 0, minus = 0;
  reg rdy = 0, rd = 0, go = 0;
  reg [3:0] half = 4'h1;
  reg [2:0] sel = 3'h1;
  reg [31:0] seed = 32'h1633;
  integer fails = 0, n_checks = 0, i, k, kk = 0, acc = 0;
  bit exp_q[$];
  bit exp_b;
  wire sck, sdi, cs_n, cal, fa, fb, sdo, strb, smode, fen_a, fen_b;
  wire [2:0] fsel;
  serial_host_model host_u (.i_core_clk(clk), .i_go(go), .i_half(half),
    .i_sel(sel), .o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n));
  meter_pulse_and_serial_timing #(.COUNTER_LOW_WIDTH(40), .CALIB_WIDTH(20))
    dut_u (.i_core_clk(clk), .i_reset(rst), .i_master_clear_n(clr_n),
    .i_offset_filter_enable(filt), .i_sck_freq_sel_hi(sck),
    .i_sdi_freq_sel_mid(sdi), .i_cs_n_freq_sel_lo(cs_n),
    .i_counter_event(cev), .i_calib_event(hev), .i_power_negative(minus),
    .i_sample_ready(rdy), .i_read_data(rd), .o_calib_pulse_out(cal),
    .o_counter_drive_a(fa), .o_counter_drive_b(fb), .o_sdo_negative(sdo),
    .o_ready_strobe(strb), .o_serial_mode(smode),
    .o_filter_ch0_enable(fen_a), .o_filter_ch1_enable(fen_b),
    .o_freq_sel(fsel));
  function automatic logic rbit();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[0];
  endfunction
  // model: active cycles expected from one or two events
  function automatic integer want(integer k, integer gap);
    integer w;
    w = k == 3 ? 4 : k == 1 ? 40 : sel == `CALIB_FIXED_CODE ? 64 : 20;
    if (k == 3 || gap == 0) return w;
    return w + (gap < 2 * w ? gap / 2 : w);
  endfunction
  // active cycles of the output under test, summed each falling edge
  always @(negedge clk) acc <= acc + (kk == 3 ? (strb === 1'b1) : kk == 1 ?
    (fa === 1'b0) + (fb === 1'b0) : (cal === 1'b1));
  task automatic fire(integer k);
    @(negedge clk);
    if (k == 3) rdy = 1; else if (k == 1) cev = 1; else hev = 1;
    @(negedge clk);
    {rdy, cev, hev} = 3'h0;
  endtask
  task automatic run(integer k, integer gap);
    kk = k;
    // clear away from the falling edge the accumulator updates on
    @(posedge clk);
    acc = 0;
    fire(k);
    if (gap > 0) begin
      repeat (gap - 2) @(negedge clk);
      fire(k);
    end
    repeat (gap + 90) @(negedge clk);
    #1 `CHK("pulse", want(k, gap), acc)
  endtask
  task wrap_up;
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up;
  end
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    for (i = 0; i < 8; i++) begin
      sel = i;
      filt = i[0];
      repeat (6) @(negedge clk);
      `CHK("fsel", sel, fsel)
      `CHK("filter", {filt, filt}, {fen_a, fen_b})
    end
    sel = 3'h0;
    run(3, 2);
    minus = 1;
    run(0, 0);
    `CHK("flag", 1'b1, sdo)
    minus = 0;
    sel = `CALIB_FIXED_CODE;
    repeat (6) @(negedge clk);
    `CHK("flag", 1'b1, sdo)
    run(0, 0);
    `CHK("flag", 1'b0, sdo)
    sel = 3'h1;
    repeat (6) @(negedge clk);
    run(0, 30);
    run(1, 0);
    run(1, 60);
    // slow entry misses the window, prompt entry is taken
    for (k = 3; k > 0; k -= 2) begin
      clr_n = 0;
      repeat (5) @(negedge clk);
      clr_n = 1;
      repeat (2) @(negedge clk);
      half = k;
      go = 1;
      @(negedge clk);
      go = 0;
      repeat (70) @(negedge clk);
      `CHK("mode", k == 1, smode)
    end
    for (i = 0; i < 8; i++) begin
      rd = rbit();
      exp_q.push_back(rd);
      @(negedge clk);
      exp_b = exp_q.pop_front();
      `CHK("sdo", exp_b, sdo)
    end
    wrap_up;
  end
endmodule
